// ===== core/dcf_fifo.sv
// fifo core with standard and fall-through read timing and status flags
// assumes writer and reader share clk; enables and data are synchronous
//
// Function
// - mode select sampled during reset: low standard, high fall-through
// - standard mode drives empty and full flags
// - fall-through mode drives output-ready and input-ready flags
// - fall-through: first word reaches outputs three edges after its write
// - write enable low stores the input word on each edge while not full
// - standard: empty flag rises after the first word is written
// - standard: almost-empty rises once n plus one words are stored
// - standard: half-full falls at word depth/2 plus one
// - standard: almost-full falls after depth minus m writes
// - standard: full flag falls at depth words; first read raises it
// - standard: almost-empty falls when n words remain
// - standard: empty flag falls after last read; reads then ignored
// - standard: empty and full flags pass two register stages
// - fall-through: output-ready falls after first word written
// - fall-through: almost-empty rises once n plus two words loaded
// - fall-through: half-full falls at word depth/2 plus two
// - fall-through: almost-full falls after depth plus one minus m writes
// - fall-through: input-ready rises at depth plus one words
// - fall-through: first read from full drops input-ready
// - fall-through: almost-empty falls when n plus one words remain
// - fall-through: output-ready rises after last read; reads ignored
// - fall-through: output-ready three stages, input-ready two stages
`timescale 1ns/1ps
module dcf_fifo #(
  parameter int WIDTH = dcf_pkg::DCF_WIDTH,
  parameter int DEPTH = dcf_pkg::DCF_DEPTH_SMALL
) (
  input logic clk,                              // core clock
  input logic rst_b,                            // full reset, active low
  input logic timing_mode_select,               // 0 standard, 1 fall-through
  input logic write_en_n,                       // write request, active low
  input logic [WIDTH-1:0] data_in,              // word to write
  input logic read_en_n,                        // read request, active low
  input logic [$clog2(DEPTH)-1:0] empty_offset, // n for almost-empty
  input logic [$clog2(DEPTH)-1:0] full_offset,  // m for almost-full
  output logic [WIDTH-1:0] fifo_data_out,       // read data
  output logic empty_flag_n,                    // standard: low when empty
  output logic full_flag_n,                     // standard: low when full
  output logic output_ready_n,                  // fall-through: low if valid
  output logic input_ready_n,                   // fall-through: high if full
  output logic half_full_n,                     // low when over half full
  output logic almost_empty_n,                  // low when almost empty
  output logic almost_full_n                    // low when almost full
);

  import dcf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2 + 1);
  localparam logic [CW-1:0] EXTRA_C = CW'(DCF_FALL_THROUGH_MODE_EXTRA);

  // ==========================================================================
  // state
  typedef struct packed {
    dcf_mode_type mode;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] wr_ptr_s;
    logic q_valid;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
    logic hf_n;
    logic ae_n;
    logic af_n;
  } dcf_fifo_state_type;

  dcf_fifo_state_type st_q;
  dcf_fifo_state_type st_d;

  logic fall_through_mode;
  logic [CW-1:0] extra;
  logic [CW-1:0] mem_cnt;
  logic [CW-1:0] total;
  logic [CW-1:0] occ;
  logic [CW-1:0] cap;
  logic [CW-1:0] hf_thr;
  logic [CW-1:0] ae_thr;
  logic [CW-1:0] af_thr;
  logic wr_acc;
  logic avail;
  logic rd_take;
  logic load_out;
  logic q_free;
  logic mem_rd;
  logic std_any;
  logic [WIDTH-1:0] mem_q;
  logic ef_raw;
  logic ff_raw;
  logic or_raw;
  logic ir_raw;

  // ==========================================================================
  // occupancy and thresholds
  assign fall_through_mode = (st_q.mode == DCF_FALL_THROUGH);
  assign extra = fall_through_mode ? EXTRA_C : '0;
  assign mem_cnt = st_q.wr_ptr - st_q.rd_ptr;
  // fall-through counts the prefetch and output registers as storage
  assign total = mem_cnt + CW'(st_q.q_valid) + CW'(st_q.out_valid);
  assign occ = fall_through_mode ? total : mem_cnt;
  assign cap = DEPTH_C + extra;
  assign hf_thr = HALF_C + extra;
  assign ae_thr = CW'(empty_offset) + extra;
  assign af_thr = DEPTH_C - CW'(full_offset) + extra;

  // ==========================================================================
  // write side
  // the memory guard only matters in a transient where both output
  // registers are empty; it keeps the ring from wrapping over itself
  assign wr_acc = !write_en_n && (occ != cap)
    && (mem_cnt != DEPTH_C);

  // ==========================================================================
  // read side
  // the reader sees the write pointer one edge late; this gives the
  // three-edge first-word path of fall-through mode
  assign avail = (st_q.wr_ptr_s != st_q.rd_ptr);
  assign rd_take = !read_en_n && st_q.out_valid;
  assign load_out = st_q.q_valid && (!st_q.out_valid || rd_take);
  assign q_free = !st_q.q_valid || load_out;
  assign std_any = (mem_cnt != '0);

  always_comb
  begin
    if (fall_through_mode)
    begin
      mem_rd = avail && q_free;
    end
    else
    begin
      mem_rd = !read_en_n && std_any;
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.wr_ptr_s = st_q.wr_ptr;
    if (wr_acc)
    begin
      st_d.wr_ptr = st_q.wr_ptr + CW'(1);
    end
    if (mem_rd)
    begin
      st_d.rd_ptr = st_q.rd_ptr + CW'(1);
    end
    if (fall_through_mode)
    begin
      if (mem_rd)
      begin
        st_d.q_valid = 1'b1;
      end
      else if (load_out)
      begin
        st_d.q_valid = 1'b0;
      end
      if (load_out)
      begin
        st_d.out_valid = 1'b1;
        st_d.out_data = mem_q;
      end
      else if (rd_take)
      begin
        st_d.out_valid = 1'b0;
      end
    end
    else
    begin
      st_d.q_valid = 1'b0;
      st_d.out_valid = 1'b0;
    end
    st_d.hf_n = !(occ >= hf_thr);
    st_d.ae_n = !(occ <= ae_thr);
    st_d.af_n = !(occ >= af_thr);
  end

  // ==========================================================================
  // state register; the mode is caught while reset is held and then kept
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.mode <= timing_mode_select ? DCF_FALL_THROUGH
        : DCF_STANDARD;
      st_q.hf_n <= DCF_HF_RST;
      st_q.ae_n <= DCF_AE_RST;
      st_q.af_n <= DCF_AF_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // storage
  dcf_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(wr_acc),
    .wr_addr(st_q.wr_ptr[AW-1:0]),
    .wr_data(data_in),
    .rd_en(mem_rd),
    .rd_addr(st_q.rd_ptr[AW-1:0]),
    .rd_data(mem_q)
  );

  // ==========================================================================
  // flag chains; in the mode that lacks them, empty and full are held low and the ready flags high
  // the pipelined full flag lags the count, so writes in that gap are
  // dropped inside rather than overrunning the memory
  assign ef_raw = fall_through_mode ? 1'b0 : std_any;
  assign ff_raw = fall_through_mode ? 1'b0 : (mem_cnt != DEPTH_C);
  assign or_raw = fall_through_mode ? (total == '0) : 1'b1;
  assign ir_raw = fall_through_mode ? (total == cap) : 1'b1;

  dcf_stages #(
    .STAGES(DCF_EF_STAGES),
    .RESET_VAL(DCF_EF_RST)
  ) u_ef (
    .clk(clk),
    .rst_b(rst_b),
    .d(ef_raw),
    .q(empty_flag_n)
  );

  dcf_stages #(
    .STAGES(DCF_FF_STAGES),
    .RESET_VAL(DCF_FF_RST)
  ) u_ff (
    .clk(clk),
    .rst_b(rst_b),
    .d(ff_raw),
    .q(full_flag_n)
  );

  dcf_stages #(
    .STAGES(DCF_OR_STAGES),
    .RESET_VAL(DCF_OR_RST)
  ) u_or (
    .clk(clk),
    .rst_b(rst_b),
    .d(or_raw),
    .q(output_ready_n)
  );

  dcf_stages #(
    .STAGES(DCF_IR_STAGES),
    .RESET_VAL(DCF_IR_RST)
  ) u_ir (
    .clk(clk),
    .rst_b(rst_b),
    .d(ir_raw),
    .q(input_ready_n)
  );

  // ==========================================================================
  // outputs
  assign fifo_data_out = fall_through_mode ? st_q.out_data : mem_q;
  assign half_full_n = st_q.hf_n;
  assign almost_empty_n = st_q.ae_n;
  assign almost_full_n = st_q.af_n;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_mode_held: assert property (
    rst_b |=> $stable(st_q.mode))
    else $error("timing mode changed outside reset");

  a_empty_two_stage: assert property (
    !fall_through_mode ##2 !fall_through_mode |-> empty_flag_n == $past(std_any, 2))
    else $error("empty flag does not follow stored count by two edges");

  a_full_flag_low: assert property (
    (!fall_through_mode && mem_cnt == DEPTH_C) |-> ##2 !full_flag_n)
    else $error("full flag not low two edges after reaching depth");

  a_full_no_store: assert property (
    (occ == cap && !write_en_n) |=> $stable(st_q.wr_ptr))
    else $error("write pointer moved while full");

  a_empty_read_ignored: assert property (
    (!fall_through_mode && mem_cnt == '0 && !read_en_n) |=>
      ($stable(fifo_data_out) && $stable(st_q.rd_ptr)))
    else $error("read while empty changed data or pointer");

  a_first_word_falls: assert property (
    (fall_through_mode && total == '0 && wr_acc) |->
      ##4 (fifo_data_out == $past(data_in, 4) && st_q.out_valid))
    else $error("first word not on outputs three edges after write");

  a_ready_three_stage: assert property (
    (fall_through_mode && total != '0) |-> ##3 !output_ready_n)
    else $error("output ready not low three edges after data stored");

  a_input_ready_full: assert property (
    (fall_through_mode && total == cap) |-> ##2 input_ready_n)
    else $error("input ready not high two edges after full");

  a_full_read_clears: assert property (
    (!fall_through_mode && mem_cnt == DEPTH_C && !read_en_n) |=> ##2 full_flag_n)
    else $error("full flag not high after first read from full");

  a_ready_in_clears: assert property (
    (fall_through_mode && total == cap && rd_take) |=> ##2 !input_ready_n)
    else $error("input ready not low after first read from full");

  a_half_full_thr: assert property (
    (occ >= hf_thr) |=> !half_full_n)
    else $error("half full flag missed threshold");

  a_almost_empty_thr: assert property (
    (occ <= ae_thr) |=> !almost_empty_n)
    else $error("almost empty flag missed threshold");

  a_almost_full_thr: assert property (
    (occ > af_thr) |-> !almost_full_n)
    else $error("almost full flag missed threshold");

  c_std_fill: cover property (!fall_through_mode && mem_cnt == DEPTH_C);
  c_fall_through_mode_full: cover property (fall_through_mode && total == cap);
  c_fall_through_mode_stream: cover property (fall_through_mode && load_out && rd_take);
  c_std_drain: cover property (!fall_through_mode && std_any ##1 !std_any);

endmodule

// ===== common/dcf_pkg.sv
// shared constants and types for the dual-mode fifo core
// assumes a single clock domain shared by the writer and the reader
package dcf_pkg;

  // ==========================================================================
  // geometry
  localparam int DCF_WIDTH = 32'h0000_0024;
  localparam int DCF_DEPTH_SMALL = 32'h0001_0000;
  localparam int DCF_DEPTH_LARGE = 32'h0002_0000;
  // fall-through keeps one word beyond the memory in its output register
  localparam int DCF_FALL_THROUGH_MODE_EXTRA = 32'h0000_0001;

  // ==========================================================================
  // flag pipeline depths and first-word latency
  localparam int DCF_EF_STAGES = 32'h0000_0002;
  localparam int DCF_FF_STAGES = 32'h0000_0002;
  localparam int DCF_OR_STAGES = 32'h0000_0003;
  localparam int DCF_IR_STAGES = 32'h0000_0002;
  localparam int DCF_FIRST_WORD_EDGES = 32'h0000_0003;

  // ==========================================================================
  // reset values of the flag outputs (active low flags)
  localparam logic DCF_EF_RST = 1'h0;
  localparam logic DCF_FF_RST = 1'h1;
  localparam logic DCF_OR_RST = 1'h1;
  localparam logic DCF_IR_RST = 1'h1;
  localparam logic DCF_HF_RST = 1'h1;
  localparam logic DCF_AE_RST = 1'h0;
  localparam logic DCF_AF_RST = 1'h1;

  // ==========================================================================
  // read timing modes
  typedef enum logic {
    DCF_STANDARD,
    DCF_FALL_THROUGH
  } dcf_mode_type;

endpackage

// ===== core/dcf_stages.sv
// flag register chain: a single bit passes a fixed number of flip-flops
// assumes STAGES is at least two and the reset is synchronous
`timescale 1ns/1ps
module dcf_stages #(
  parameter int STAGES = 2,
  parameter logic RESET_VAL = 1'h0
) (
  input logic clk,   // core clock
  input logic rst_b, // synchronous reset, active low
  input logic d,     // raw flag level
  output logic q     // flag after the last stage
);

  typedef struct packed {
    logic [STAGES-1:0] sh;
  } dcf_stage_state_type;

  dcf_stage_state_type st_q;
  dcf_stage_state_type st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.sh[0] = d;
    for (int i = 1; i < STAGES; i++)
    begin
      st_d.sh[i] = st_q.sh[i-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= '{sh: {STAGES{RESET_VAL}}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.sh[STAGES-1];

endmodule

// ===== core/dcf_mem.sv
// word storage of the fifo: one write port, one read port, read data held
// in a register until the next read; contents are not reset
`timescale 1ns/1ps
module dcf_mem #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 65536
) (
  input logic clk,                         // core clock
  input logic rst_b,                       // synchronous reset, active low
  input logic wr_en,                       // store wr_data this edge
  input logic [$clog2(DEPTH)-1:0] wr_addr, // write location
  input logic [WIDTH-1:0] wr_data,         // word to store
  input logic rd_en,                       // load rd_data this edge
  input logic [$clog2(DEPTH)-1:0] rd_addr, // read location
  output logic [WIDTH-1:0] rd_data         // registered read word
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // rd_data only moves on rd_en, so an ignored read leaves it untouched
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ===== bench/dcf_partner.sv
// writer and reader model facing the fifo core
// assumes the bench calls its tasks from one process, one call per edge
`timescale 1ns/1ps
module dcf_partner #(
  parameter int W = 36
) (
  input logic clk,              // core clock
  output logic write_en_n,      // write request, active low
  output logic [W-1:0] data_in, // word offered
  output logic read_en_n        // read request, active low
);
  initial
  begin
    write_en_n = 1'h1;
    read_en_n = 1'h1;
    data_in = '0;
  end

  // enable and word held through the edge that samples them
  task automatic put(input logic [W-1:0] w);
    @(posedge clk);
    write_en_n <= 1'h0;
    data_in <= w;
  endtask

  // every word is asked for, the first one too in standard mode
  task automatic get();
    @(posedge clk);
    read_en_n <= 1'h0;
  endtask

  // released data lines flip so a stale word never looks valid
  task automatic idle(input int k);
    repeat (k)
    begin
      @(posedge clk);
      write_en_n <= 1'h1;
      read_en_n <= 1'h1;
      data_in <= ~data_in;
    end
  endtask
endmodule

// ===== bench/dcf_fifo_tb_top.sv
// self-checking bench for the fifo core in both read timing modes
// assumes one clock for writer and reader and a small depth
`timescale 1ns/1ps
module dcf_fifo_tb_top;
  import dcf_pkg::*;
  localparam int D = 16;
  localparam int AW = $clog2(D);
  localparam int W = DCF_WIDTH;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic timing_mode_select = 1'h0;
  logic write_en_n;
  logic read_en_n;
  logic [DCF_WIDTH-1:0] data_in;
  logic [DCF_WIDTH-1:0] fifo_data_out;
  logic [AW-1:0] empty_offset = '0;
  logic [AW-1:0] full_offset = '0;
  logic empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  logic half_full_n, almost_empty_n, almost_full_n;
  logic [DCF_WIDTH-1:0] exp_q[$];
  logic [DCF_WIDTH-1:0] last_q = '0;
  int n_fail = 0;
  int comparisons = 0;
  int cnt = 0;
  int cycles = 0;
  bit f = 1'h0;
  bit pend = 1'h0;

  always #5 clk = ~clk;

  dcf_partner #(.W(DCF_WIDTH)) u_partner (
    .clk(clk),
    .write_en_n(write_en_n),
    .data_in(data_in),
    .read_en_n(read_en_n)
  );

  dcf_fifo #(.WIDTH(DCF_WIDTH), .DEPTH(D)) u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .timing_mode_select(timing_mode_select),
    .write_en_n(write_en_n),
    .data_in(data_in),
    .read_en_n(read_en_n),
    .empty_offset(empty_offset),
    .full_offset(full_offset),
    .fifo_data_out(fifo_data_out),
    .empty_flag_n(empty_flag_n),
    .full_flag_n(full_flag_n),
    .output_ready_n(output_ready_n),
    .input_ready_n(input_ready_n),
    .half_full_n(half_full_n),
    .almost_empty_n(almost_empty_n),
    .almost_full_n(almost_full_n)
  );

  // ==========================================================================
  // checking
  task automatic check(input logic [DCF_WIDTH-1:0] got,
                       input logic [DCF_WIDTH-1:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // order: empty, full, ready out, ready in, half, almost empty, almost full
  function automatic logic [6:0] flags_exp(input int c);
    logic [6:0] e;
    e[6] = f ? 1'h0 : c != 0;
    e[5] = f ? 1'h0 : c != D;
    e[4] = f ? c == 0 : 1'h1;
    e[3] = f ? c == D + 1 : 1'h1;
    e[2] = c < D / 2 + 1 + int'(f);
    e[1] = c > int'(empty_offset) + int'(f);
    e[0] = c < D + int'(f) - int'(full_offset);
    return e;
  endfunction

  // fixed wait covers the longest flag pipeline plus refill
  task automatic settle();
    logic [6:0] e;
    u_partner.idle(6);
    @(negedge clk);
    e = flags_exp(cnt);
    check(W'(empty_flag_n), W'(e[6]), "ef");
    check(W'(full_flag_n), W'(e[5]), "ff");
    check(W'(output_ready_n), W'(e[4]), "or");
    check(W'(input_ready_n), W'(e[3]), "ir");
    check(W'(half_full_n), W'(e[2]), "hf");
    check(W'(almost_empty_n), W'(e[1]), "ae");
    check(W'(almost_full_n), W'(e[0]), "af");
  endtask

  // ==========================================================================
  // reference occupancy; a standard read word is seen one edge later
  always @(negedge clk)
  begin
    bit wr_ok;
    bit rd_ok;
    if (pend)
    begin
      last_q = exp_q.pop_front();
      check(fifo_data_out, last_q, "std word");
    end
    wr_ok = rst_b === 1'h1 && write_en_n === 1'h0 && cnt < D + int'(f);
    rd_ok = rst_b === 1'h1 && read_en_n === 1'h0 && cnt > 0;
    pend = rd_ok && !f;
    if (rd_ok && f)
    begin
      last_q = exp_q.pop_front();
      check(fifo_data_out, last_q, "fall_through_mode word");
    end
    if (wr_ok)
      exp_q.push_back(data_in);
    cnt = cnt + int'(wr_ok) - int'(rd_ok);
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic run_mode(input bit mode);
    logic [DCF_WIDTH-1:0] w;
    @(posedge clk);
    f = mode;
    cnt = 0;
    exp_q.delete();
    rst_b <= 1'h0;
    timing_mode_select <= mode;
    empty_offset <= AW'($urandom_range(D - 3, 1));
    full_offset <= AW'($urandom_range(D - 3, 1));
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    // select flips after release and must be ignored
    timing_mode_select <= ~mode;
    settle();
    w = DCF_WIDTH'({$urandom, $urandom});
    u_partner.put(w);
    u_partner.idle(1);
    @(negedge clk);
    check(W'(empty_flag_n), W'(1'h0), "c1");
    check(W'(output_ready_n), W'(1'h1), "c1");
    // one edge after the write the level is still inside the chain
    @(negedge clk);
    check(W'(empty_flag_n), W'(1'h0), "c2");
    @(negedge clk);
    check(W'(empty_flag_n), W'(!mode), "c3");
    check(W'(output_ready_n), W'(1'h1), "c3");
    @(negedge clk);
    check(W'(output_ready_n), W'(!mode), "c4");
    check(fifo_data_out, mode ? w : '0, "first");
    for (int i = 1; i < D + int'(mode); i++)
    begin
      settle();
      u_partner.put(DCF_WIDTH'({$urandom, $urandom}));
    end
    settle();
    // writes into a full fifo are dropped
    u_partner.put(DCF_WIDTH'({$urandom, $urandom}));
    u_partner.put(DCF_WIDTH'({$urandom, $urandom}));
    settle();
    while (cnt > 0)
    begin
      u_partner.get();
      settle();
    end
    // reads while empty leave the word on the outputs alone
    u_partner.get();
    u_partner.get();
    settle();
    check(fifo_data_out, last_q, "empty read");
    if (!mode)
    begin
      repeat (3) u_partner.put(DCF_WIDTH'({$urandom, $urandom}));
      u_partner.idle(3);
      repeat (3) u_partner.get();
      settle();
    end
  endtask

  initial
  begin
    void'($urandom(58));
    run_mode(1'h0);
    run_mode(1'h1);
    print_verdict();
  end
endmodule
